// ### verilog/line_mode_defs.svh
`ifndef LINE_MODE_DEFS_SVH
`define LINE_MODE_DEFS_SVH

// ***********************************************
// Register offsets
// ***********************************************
`define ADDR_W 4
`define OFS_LINE_CTRL 4'h0
`define OFS_HOOK_CTRL 4'h4
`define OFS_STATUS 4'h8

// ***********************************************
// Field positions
// ***********************************************
`define BIT_MODE 0
`define BIT_RING_ZERO 1
`define BIT_FULL_WAVE 2
`define BIT_SQUELCH 3
`define BIT_CID_SQUELCH 4
`define BIT_HOOK_REQ 0
`define BIT_MON_EN 1
`define BIT_OFFHOOK_DONE 0
`define BIT_OVERRUN 1
`define BIT_SQUELCH_DONE 2
`define SENSE_HI 7
`define SENSE_LO 3

// ***********************************************
// Reset values and constants
// ***********************************************
`define LINE_CTRL_RST 5'h00
`define HOOK_CTRL_RST 2'h0
`define SENSE_RST 5'h00
`define SENSE_ALL_ONES 5'h1F
`define SENSE_ALL_ZEROS 5'h00

// ***********************************************
// Timing
// ***********************************************
`define CLK_MHZ 100
`define SQUELCH_TIME_US 1000
`define OFFHOOK_CYCLES_DEF 1000
`define RING_THRESH_DEF 8'h20

`endif

// ### verilog/line_mode_pkg.sv
package line_mode_pkg;

  typedef enum logic [1:0] {
    LS_ON_HOOK = 2'b00,
    LS_OFF_HOOK = 2'b01,
    LS_FAST_SETTLE = 2'b10,
    LS_FORCE_ON_HOOK = 2'b11
  } line_state_t;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_LINE = 2'b01,
    SEL_RING = 2'b10
  } data_sel_t;

endpackage

// ### verilog/sample_fifo.sv
`timescale 1ns/1ps

module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic push;
  logic pop;

  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("sample_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  assign in_ready_out = (count_reg != CW'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem_reg[rd_ptr_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + PW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + CW'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - CW'(1);
      end
    end
  end

endmodule

// ### verilog/line_mode_ring_control.sv
// Behaviour
// - Ring-zero reporting during a ring: sense reads all ones with voltage, else zeros.
// - Force on-hook goes on-hook but keeps the off-hook counter.
// - Fast settle mode goes off-hook to settle line voltage quickly.
// - Full-wave select: 0 half-wave, 1 full-wave ring rectification.
// - Rectification applies to ring detect pin and ring data stream.
// - Sense field shows voltage, loop current or the ring-zero report per mode bits.
`timescale 1ns/1ps
`include "line_mode_defs.svh"

module line_mode_ring_control #(
  parameter int OFFHOOK_CYCLES = `OFFHOOK_CYCLES_DEF,
  parameter int SQUELCH_CYCLES = `SQUELCH_TIME_US * `CLK_MHZ,
  parameter int FIFO_DEPTH = 8,
  parameter logic [7:0] RING_THRESH = `RING_THRESH_DEF
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [`ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [4:0] line_voltage_in,
  input wire logic [4:0] loop_current_in,
  input wire logic ring_event_in,
  input wire logic sample_strobe_in,
  input wire logic [7:0] line_sample_in,
  input wire logic [7:0] ring_sample_in,
  output logic serial_data_valid_out,
  input wire logic serial_data_ready_in,
  output logic [7:0] serial_data_out,
  output logic hook_engage_out,
  output logic fast_settle_out,
  output logic monitor_low_out,
  output logic monitor_high_out,
  output logic ring_detect_pin_out,
  output logic ring_network_squelch_out,
  output logic cid_squelch_out
);

  localparam int OCW = $clog2(OFFHOOK_CYCLES + 1);
  localparam int SCW = $clog2(SQUELCH_CYCLES + 1);

  generate
    if (OFFHOOK_CYCLES < 1 || SQUELCH_CYCLES < 1) begin : g_bad_count
      $error("counts must be at least one cycle");
    end
  endgenerate

  // ***********************************************
  // Helpers
  // ***********************************************
  function automatic line_mode_pkg::line_state_t decode_state(input logic mode,
      input logic hook, input logic mon);
    case ({mode, hook})
      2'b01: decode_state = mon ? line_mode_pkg::LS_FAST_SETTLE : line_mode_pkg::LS_OFF_HOOK;
      2'b11: decode_state = line_mode_pkg::LS_FORCE_ON_HOOK;
      default: decode_state = line_mode_pkg::LS_ON_HOOK;
    endcase
  endfunction

  function automatic line_mode_pkg::data_sel_t decode_sel(input logic mode,
      input logic hook, input logic mon);
    if (!mode && !hook && !mon) begin
      decode_sel = line_mode_pkg::SEL_NONE;
    end else if (mode && !hook && !mon) begin
      decode_sel = line_mode_pkg::SEL_RING;
    end else if (mode && hook && !mon) begin
      decode_sel = line_mode_pkg::SEL_NONE;
    end else begin
      decode_sel = line_mode_pkg::SEL_LINE;
    end
  endfunction

  function automatic logic [7:0] rectify(input logic [7:0] s, input logic full);
    if (!s[7]) begin
      rectify = s;
    end else if (full) begin
      rectify = 8'h00 - s;
    end else begin
      rectify = 8'h00;
    end
  endfunction

  // ***********************************************
  // Pin synchronisers
  // ***********************************************
  logic [10:0] pin_s1_reg;
  logic [10:0] pin_s2_reg;
  logic [4:0] volt_s;
  logic [4:0] loop_s;
  logic ring_ev_s;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pin_s1_reg <= 11'h000;
      pin_s2_reg <= 11'h000;
    end else begin
      pin_s1_reg <= {ring_event_in, loop_current_in, line_voltage_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign volt_s = pin_s2_reg[4:0];
  assign loop_s = pin_s2_reg[9:5];
  assign ring_ev_s = pin_s2_reg[10];

  // ***********************************************
  // Control registers
  // ***********************************************
  logic [4:0] line_ctrl_reg;
  logic [1:0] hook_ctrl_reg;
  logic mode_bit;
  logic ring_zero_report;
  logic ring_full_wave_select;
  logic hook_request;
  logic line_monitor_enable;

  assign mode_bit = line_ctrl_reg[`BIT_MODE];
  assign ring_zero_report = line_ctrl_reg[`BIT_RING_ZERO];
  assign ring_full_wave_select = line_ctrl_reg[`BIT_FULL_WAVE];
  assign hook_request = hook_ctrl_reg[`BIT_HOOK_REQ];
  assign line_monitor_enable = hook_ctrl_reg[`BIT_MON_EN];

  // Mode and hook bits sit in separate registers; each write lands on its own
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      line_ctrl_reg <= `LINE_CTRL_RST;
      hook_ctrl_reg <= `HOOK_CTRL_RST;
    end else if (wr_in) begin
      if (addr_in == `OFS_LINE_CTRL) begin
        line_ctrl_reg <= wdata_in[4:0];
      end else if (addr_in == `OFS_HOOK_CTRL) begin
        hook_ctrl_reg <= wdata_in[1:0];
      end
    end
  end

  // ***********************************************
  // Line state and outputs
  // ***********************************************
  line_mode_pkg::line_state_t st_now;
  line_mode_pkg::line_state_t state_reg;
  line_mode_pkg::data_sel_t sel_now;
  logic hook_engage_reg;
  logic fast_settle_reg;
  logic monitor_low_reg;
  logic monitor_high_reg;
  logic squelch_reg;
  logic cid_squelch_reg;

  assign st_now = decode_state(mode_bit, hook_request, line_monitor_enable);
  assign sel_now = decode_sel(mode_bit, hook_request, line_monitor_enable);

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_reg <= line_mode_pkg::LS_ON_HOOK;
      hook_engage_reg <= 1'b0;
      fast_settle_reg <= 1'b0;
      monitor_low_reg <= 1'b0;
      monitor_high_reg <= 1'b0;
      squelch_reg <= 1'b0;
      cid_squelch_reg <= 1'b0;
    end else begin
      state_reg <= st_now;
      hook_engage_reg <= (st_now == line_mode_pkg::LS_OFF_HOOK) ||
                         (st_now == line_mode_pkg::LS_FAST_SETTLE);
      fast_settle_reg <= (st_now == line_mode_pkg::LS_FAST_SETTLE);
      monitor_low_reg <= mode_bit && line_monitor_enable;
      monitor_high_reg <= !mode_bit && !hook_request && line_monitor_enable;
      squelch_reg <= line_ctrl_reg[`BIT_SQUELCH];
      cid_squelch_reg <= line_ctrl_reg[`BIT_CID_SQUELCH];
    end
  end

  // Off-hook counter: cleared only by a true on-hook, frozen in force on-hook
  logic [OCW-1:0] offhook_cnt_reg;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      offhook_cnt_reg <= '0;
    end else if (state_reg == line_mode_pkg::LS_ON_HOOK) begin
      offhook_cnt_reg <= '0;
    end else if (state_reg != line_mode_pkg::LS_FORCE_ON_HOOK &&
                 offhook_cnt_reg != OCW'(OFFHOOK_CYCLES)) begin
      offhook_cnt_reg <= offhook_cnt_reg + OCW'(1);
    end
  end

  // Squelch hold timer, visible to software
  logic [SCW-1:0] squelch_cnt_reg;

  always_ff @(posedge clk_in) begin
    if (!nrst_in || !squelch_reg) begin
      squelch_cnt_reg <= '0;
    end else if (squelch_cnt_reg != SCW'(SQUELCH_CYCLES)) begin
      squelch_cnt_reg <= squelch_cnt_reg + SCW'(1);
    end
  end

  // ***********************************************
  // Line sense value
  // ***********************************************
  logic [4:0] sense_next;
  logic [4:0] line_sense_value_reg;

  always_comb begin
    if (ring_zero_report && ring_ev_s) begin
      sense_next = (volt_s != 5'h00) ? `SENSE_ALL_ONES : `SENSE_ALL_ZEROS;
    end else if (st_now == line_mode_pkg::LS_OFF_HOOK ||
                 st_now == line_mode_pkg::LS_FAST_SETTLE) begin
      sense_next = loop_s;
    end else begin
      sense_next = volt_s;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      line_sense_value_reg <= `SENSE_RST;
    end else begin
      line_sense_value_reg <= sense_next;
    end
  end

  // ***********************************************
  // Ring detection and data stream
  // ***********************************************
  logic [7:0] ring_rect;
  logic ring_detect_reg;
  logic pend_valid_reg;
  logic [7:0] pend_data_reg;
  logic pend_load;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic out_valid_reg;
  logic [7:0] out_data_reg;
  logic overrun_reg;
  logic overrun_set;

  assign ring_rect = rectify(ring_sample_in, ring_full_wave_select);
  assign pend_load = sample_strobe_in && sel_now != line_mode_pkg::SEL_NONE &&
                     (!pend_valid_reg || fifo_in_ready);
  assign overrun_set = sample_strobe_in && sel_now != line_mode_pkg::SEL_NONE && !pend_load;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ring_detect_reg <= 1'b0;
    end else if (sample_strobe_in) begin
      ring_detect_reg <= (ring_rect > RING_THRESH);
    end
  end

  // Pending word stalls when the FIFO is full
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pend_valid_reg <= 1'b0;
      pend_data_reg <= 8'h00;
    end else if (pend_load) begin
      pend_valid_reg <= 1'b1;
      pend_data_reg <= (sel_now == line_mode_pkg::SEL_RING) ? ring_rect : line_sample_in;
    end else if (fifo_in_ready) begin
      pend_valid_reg <= 1'b0;
    end
  end

  // Set wins over a software clear
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      overrun_reg <= 1'b0;
    end else if (overrun_set) begin
      overrun_reg <= 1'b1;
    end else if (wr_in && addr_in == `OFS_STATUS && wdata_in[`BIT_OVERRUN]) begin
      overrun_reg <= 1'b0;
    end
  end

  sample_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(pend_valid_reg),
    .in_ready_out(fifo_in_ready),
    .in_data_in(pend_data_reg),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data)
  );

  assign fifo_out_ready = !out_valid_reg || serial_data_ready_in;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= 8'h00;
    end else if (fifo_out_ready) begin
      out_valid_reg <= fifo_out_valid;
      out_data_reg <= fifo_out_data;
    end
  end

  // ***********************************************
  // Register read
  // ***********************************************
  logic [7:0] rdata_reg;

  always_ff @(posedge clk_in) begin
    if (!nrst_in || !rd_in) begin
      rdata_reg <= 8'h00;
    end else if (addr_in == `OFS_LINE_CTRL) begin
      rdata_reg <= {3'h0, line_ctrl_reg};
    end else if (addr_in == `OFS_HOOK_CTRL) begin
      rdata_reg <= {6'h00, hook_ctrl_reg};
    end else if (addr_in == `OFS_STATUS) begin
      rdata_reg <= {line_sense_value_reg, squelch_cnt_reg == SCW'(SQUELCH_CYCLES),
                    overrun_reg, offhook_cnt_reg == OCW'(OFFHOOK_CYCLES)};
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata_out = rdata_reg;
  assign serial_data_valid_out = out_valid_reg;
  assign serial_data_out = out_data_reg;
  assign hook_engage_out = hook_engage_reg;
  assign fast_settle_out = fast_settle_reg;
  assign monitor_low_out = monitor_low_reg;
  assign monitor_high_out = monitor_high_reg;
  assign ring_detect_pin_out = ring_detect_reg;
  assign ring_network_squelch_out = squelch_reg;
  assign cid_squelch_out = cid_squelch_reg;

  // ***********************************************
  // Assertions
  // ***********************************************
  a_ring_zero_sense: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ring_zero_report && ring_ev_s |=> line_sense_value_reg == ($past(volt_s) != 5'h00 ?
    5'h1F : 5'h00)) else $error("ring zero sense wrong");
  a_force_count_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_reg == line_mode_pkg::LS_FORCE_ON_HOOK) [*2] |-> $stable(offhook_cnt_reg) &&
    !hook_engage_reg) else $error("force on-hook disturbed counter");
  a_fast_settle_hook: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !mode_bit && hook_request && line_monitor_enable |=> hook_engage_out && fast_settle_out)
    else $error("fast settle not off-hook");
  a_half_wave_drop: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pend_load && sel_now == line_mode_pkg::SEL_RING && !ring_full_wave_select &&
    ring_sample_in[7] |=> pend_data_reg == 8'h00) else $error("half wave passed negative");
  a_ring_pin_rect: assert property (@(posedge clk_in) disable iff (!nrst_in)
    sample_strobe_in |=> ring_detect_pin_out ==
    (rectify($past(ring_sample_in), $past(ring_full_wave_select)) > RING_THRESH))
    else $error("ring pin rectification wrong");
  a_loop_sense: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !(ring_zero_report && ring_ev_s) && st_now == line_mode_pkg::LS_OFF_HOOK |=>
    line_sense_value_reg == $past(loop_s)) else $error("loop current not reported");
  a_force_silent: assert property (@(posedge clk_in) disable iff (!nrst_in)
    mode_bit && hook_request && !line_monitor_enable |-> !pend_load)
    else $error("force on-hook sent data");
  a_low_monitor: assert property (@(posedge clk_in) disable iff (!nrst_in)
    mode_bit && line_monitor_enable |=> monitor_low_out && !hook_engage_out)
    else $error("low current monitor not selected");

endmodule

// ### tb/line_sink_model.sv
`timescale 1ns/1ps
// ****************************************
// Stream sink that can stall and records every word
// ****************************************
module line_sink_model (
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic valid_in,
  input wire logic [7:0] data_in,
  output logic ready_out
);
  logic [7:0] got[$];
  assign ready_out = !stall_in;
  always @(posedge clk_in) begin
    if (valid_in && ready_out) begin
      got.push_back(data_in);
    end
  end
endmodule

// ### tb/line_mode_ring_control_tb_top.sv
`timescale 1ns/1ps
`include "line_mode_defs.svh"
module line_mode_ring_control_tb_top;
  logic clk_in, nrst_in, wr_in, rd_in, ring_event_in, strobe, stall, rdy, vld;
  logic [3:0] addr_in;
  logic [7:0] wdata_in, rdata_out, line_s, ring_s, sdata, d;
  logic [4:0] volt, cur;
  logic [4:0] lc;
  logic hk;
  logic engage, fast, mlow, mhigh, rpin, sq, cid;
  int err_total, checked, cycles, n;
  logic [7:0] rs[5] = '{8'hC0, 8'hC0, 8'h30, 8'h80, 8'h10};
  logic [7:0] rw[5] = '{8'h00, 8'h40, 8'h30, 8'h80, 8'h10};
  logic rf[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic rp[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  line_mode_ring_control #(.OFFHOOK_CYCLES(10), .SQUELCH_CYCLES(20), .FIFO_DEPTH(8)) u_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .line_voltage_in(volt),
    .loop_current_in(cur), .ring_event_in(ring_event_in), .sample_strobe_in(strobe),
    .line_sample_in(line_s), .ring_sample_in(ring_s), .serial_data_valid_out(vld),
    .serial_data_ready_in(rdy), .serial_data_out(sdata), .hook_engage_out(engage),
    .fast_settle_out(fast), .monitor_low_out(mlow), .monitor_high_out(mhigh),
    .ring_detect_pin_out(rpin), .ring_network_squelch_out(sq), .cid_squelch_out(cid));

  line_sink_model u_sink (.clk_in(clk_in), .stall_in(stall), .valid_in(vld),
    .data_in(sdata), .ready_out(rdy));

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
    v = rdata_out;
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask

  // Monitor cleared first, hook next, mode next, monitor set in its own write
  task automatic set_state(input logic m, input logic h, input logic o);
    wr(`OFS_HOOK_CTRL, {7'h00, hk});
    hk = h;
    wr(`OFS_HOOK_CTRL, {7'h00, hk});
    lc[0] = m;
    wr(`OFS_LINE_CTRL, {3'h0, lc});
    if (o) begin
      wr(`OFS_HOOK_CTRL, {6'h00, o, h});
    end
  endtask

  task automatic sample(input logic [7:0] l, input logic [7:0] r);
    @(posedge clk_in);
    strobe <= 1'b1;
    line_s <= l;
    ring_s <= r;
    @(posedge clk_in);
    strobe <= 1'b0;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {nrst_in, wr_in, rd_in, ring_event_in, strobe, stall} = '0;
    addr_in = '0;
    wdata_in = '0;
    line_s = '0;
    ring_s = '0;
    volt = 5'h0A;
    cur = 5'h15;
    lc = '0;
    hk = 1'b0;
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(`OFS_LINE_CTRL, d); check(d, 8'h00);
    rd(`OFS_HOOK_CTRL, d); check(d, 8'h00);
    rd(4'hC, d); check(d, 8'h00);
    wr(4'hC, 8'hFF);
    rd(`OFS_LINE_CTRL, d); check(d, 8'h00);
    wait_cyc(1); check(rdata_out, 8'h00);
    for (int i = 0; i < 8; i++) begin
      set_state(i[2], i[1], i[0]);
      wait_cyc(6);
      check({4'h0, engage, fast, mlow, mhigh}, {4'h0, !i[2] && i[1], i == 3,
        i[2] && i[0], i == 1});
      rd(`OFS_STATUS, d);
      check({3'h0, d[7:3]}, {3'h0, (i == 2 || i == 3) ? cur : volt});
    end
    set_state(1'b0, 1'b1, 1'b0);
    wait_cyc(15);
    rd(`OFS_STATUS, d); check({7'h00, d[0]}, 8'h01);
    set_state(1'b1, 1'b1, 1'b0);
    wait_cyc(15);
    check({7'h00, engage}, 8'h00);
    set_state(1'b0, 1'b1, 1'b0);
    rd(`OFS_STATUS, d); check({7'h00, d[0]}, 8'h01);
    set_state(1'b1, 1'b0, 1'b0);
    wait_cyc(3);
    rd(`OFS_STATUS, d); check({7'h00, d[0]}, 8'h00);
    lc[1] = 1'b1;
    wr(`OFS_LINE_CTRL, {3'h0, lc});
    ring_event_in <= 1'b1;
    wait_cyc(6);
    rd(`OFS_STATUS, d); check({3'h0, d[7:3]}, 8'h1F);
    volt <= 5'h00;
    wait_cyc(6);
    rd(`OFS_STATUS, d); check({3'h0, d[7:3]}, 8'h00);
    ring_event_in <= 1'b0;
    volt <= 5'h0A;
    lc[1] = 1'b0;
    for (int i = 0; i < 5; i++) begin
      lc[2] = rf[i];
      wr(`OFS_LINE_CTRL, {3'h0, lc});
      n = u_sink.got.size();
      sample(8'h5A, rs[i]);
      wait_cyc(8);
      check(u_sink.got.size() - n, 8'h01);
      check(u_sink.got[u_sink.got.size() - 1], rw[i]);
      check({7'h00, rpin}, {7'h00, rp[i]});
    end
    lc[2] = 1'b0;
    set_state(1'b0, 1'b1, 1'b0);
    n = u_sink.got.size();
    stall <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      sample(8'hA0 + i[7:0], 8'h00);
    end
    wait_cyc(4);
    rd(`OFS_STATUS, d); check({7'h00, d[1]}, 8'h01);
    stall <= 1'b0;
    wait_cyc(30);
    check(u_sink.got.size() - n, 8'h0A);
    for (int i = 0; i < 10; i++) begin
      check(u_sink.got[n + i], 8'hA0 + i[7:0]);
    end
    wr(`OFS_STATUS, 8'h02);
    rd(`OFS_STATUS, d); check({7'h00, d[1]}, 8'h00);
    set_state(1'b1, 1'b1, 1'b0);
    n = u_sink.got.size();
    sample(8'h33, 8'h33);
    wait_cyc(8);
    check(u_sink.got.size() - n, 8'h00);
    lc[3] = 1'b1;
    wr(`OFS_LINE_CTRL, {3'h0, lc});
    wait_cyc(2);
    check({7'h00, sq}, 8'h01);
    wait_cyc(25);
    rd(`OFS_STATUS, d); check({7'h00, d[2]}, 8'h01);
    lc[3] = 1'b0;
    wr(`OFS_LINE_CTRL, {3'h0, lc});
    wait_cyc(2);
    check({7'h00, sq}, 8'h00);
    lc[4] = 1'b1;
    wr(`OFS_LINE_CTRL, {3'h0, lc});
    wait_cyc(2);
    check({7'h00, cid}, 8'h01);
    rd(`OFS_LINE_CTRL, d); check(d, {3'h0, lc});
    print_verdict();
  end
endmodule
